// ---- design/flash_frame.sv ----
// Serial flash command framing: link-side deframer on the SPI clock, core side on sys_clk.
// Assumes a host SPI master in mode 0 or 3 and an array/status core beside it.
//
// Contract
// - Decode 24-bit addresses into 4 KB sectors.
// - Invalid opcode: standby until select rises.
// - Standby keeps serial output high impedance.
// - Valid opcode stays active until select rises.
// - Sample on rising clock, shift on falling.
// - Works in SPI mode 0 and 3.
// - Reads stream out; any bit may end.
// - Write-type frames must end on bytes.
// - Array access ignored while busy.
`timescale 1ns/100ps
`default_nettype none
`include "flash_frame_regs.svh"
module flash_frame (
    // System clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // SPI pins; the SPI clock is the link domain clock.
    input  wire logic        spi_clk,
    input  wire logic        cs_n,
    input  wire logic        si,
    output logic             so_dat,
    output logic             so_oe,
    // Core command output, buffered.
    output logic             cmd_valid,
    input  wire logic        cmd_ready,
    output logic [3:0]       cmd_code,
    output logic [23:0]      cmd_addr,
    // Core status inputs.
    input  wire logic        busy,
    input  wire logic [7:0]  status_byte,
    input  wire logic [7:0]  id_byte,
    input  wire logic [7:0]  array_byte,
    // Protection and geometry indications.
    output logic             addr_locked,
    output logic [9:0]       addr_sector,
    output logic [5:0]       addr_block,
    output logic             cmd_dropped
);
    ////////////////////////////////////////////////////////////////////////////
    // Link domain: deframer on spi_clk, reset asynchronously by chip select; the frame-end fields and the select toggle reset by rstn.
    logic [2:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [1:0]  byte_cnt_r;
    logic        active_r;
    logic        standby_r;
    logic        have_op_r;
    flash_frame_pkg::cmd_t op_r;
    flash_frame_pkg::cmd_t op_nxt;
    logic [23:0] addr_r;
    logic        addr_done_r;
    logic [7:0]  out_sh_r;
    logic        out_bit_r;
    logic [3:0]  pend_code_r;
    logic [23:0] pend_addr_r;
    logic        frame_aligned_r;
    logic [7:0]  byte_in;
    logic        is_read;
    logic        needs_addr;
    logic        busy_l1_r;
    logic        busy_l2_r;

    assign byte_in = {shift_r[6:0], si};

    // Opcode decode; anything outside the supported set is invalid.
    always_comb begin
        case (byte_in)
            `OP_READ:      op_nxt = flash_frame_pkg::CMD_READ;
            `OP_FAST_READ: op_nxt = flash_frame_pkg::CMD_FAST_READ;
            `OP_RDSR:      op_nxt = flash_frame_pkg::CMD_RDSR;
            `OP_RDID:      op_nxt = flash_frame_pkg::CMD_RDID;
            `OP_WREN:      op_nxt = flash_frame_pkg::CMD_WREN;
            `OP_WRDI:      op_nxt = flash_frame_pkg::CMD_WRDI;
            `OP_SE:        op_nxt = flash_frame_pkg::CMD_SE;
            `OP_BE:        op_nxt = flash_frame_pkg::CMD_BE;
            `OP_PP:        op_nxt = flash_frame_pkg::CMD_PP;
            `OP_SBLK:      op_nxt = flash_frame_pkg::CMD_LOCK;
            `OP_SBULK:     op_nxt = flash_frame_pkg::CMD_UNLOCK;
            default:       op_nxt = flash_frame_pkg::CMD_NONE;
        endcase
    end

    assign is_read = (op_r == flash_frame_pkg::CMD_READ) ||
                     (op_r == flash_frame_pkg::CMD_FAST_READ) ||
                     (op_r == flash_frame_pkg::CMD_RDSR) ||
                     (op_r == flash_frame_pkg::CMD_RDID);
    assign needs_addr = (op_r == flash_frame_pkg::CMD_READ) ||
                        (op_r == flash_frame_pkg::CMD_FAST_READ) ||
                        (op_r == flash_frame_pkg::CMD_SE) ||
                        (op_r == flash_frame_pkg::CMD_BE) ||
                        (op_r == flash_frame_pkg::CMD_PP) ||
                        (op_r == flash_frame_pkg::CMD_LOCK) ||
                        (op_r == flash_frame_pkg::CMD_UNLOCK);

    // Busy is a level from sys_clk, brought over with two link flops.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            busy_l1_r <= 1'b0;
            busy_l2_r <= 1'b0;
        end else begin
            busy_l1_r <= busy;
            busy_l2_r <= busy_l1_r;
        end
    end

    // Input sampling on the rising edge; cleared while select is high.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_r  <= 3'h0;
            shift_r    <= 8'h00;
            byte_cnt_r <= 2'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r   <= byte_in;
            if (bit_cnt_r == 3'h7 && byte_cnt_r != 2'h3 && have_op_r) begin
                byte_cnt_r <= byte_cnt_r + 2'h1;
            end
        end
    end

    // Frame state: opcode capture, active or standby until select changes.
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            have_op_r   <= 1'b0;
            active_r    <= 1'b0;
            standby_r   <= 1'b0;
            op_r        <= flash_frame_pkg::CMD_NONE;
            addr_r      <= 24'h00_0000;
            addr_done_r <= 1'b0;
        end else if (!have_op_r && !standby_r && bit_cnt_r == 3'h7) begin
            have_op_r <= 1'b1;
            op_r      <= op_nxt;
            if (op_nxt == flash_frame_pkg::CMD_NONE) begin
                standby_r <= 1'b1;
            end else begin
                active_r <= 1'b1;
            end
        end else if (active_r && needs_addr && !addr_done_r) begin
            addr_r <= {addr_r[22:0], si};
            if (bit_cnt_r == 3'h7 && byte_cnt_r == 2'h2) begin
                addr_done_r <= 1'b1;
            end
        end
    end

    // Reads with array access are dropped while the core is busy.
    logic read_blocked;
    assign read_blocked = busy_l2_r && (op_r == flash_frame_pkg::CMD_READ ||
                                        op_r == flash_frame_pkg::CMD_FAST_READ);

    // Output shifter changes on the falling edge; any bit may be the last.
    always_ff @(negedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            out_sh_r  <= 8'h00;
            out_bit_r <= 1'b0;
        end else if (active_r && is_read && !read_blocked &&
                     (!needs_addr || addr_done_r)) begin
            if (bit_cnt_r == 3'h0) begin
                case (op_r)
                    flash_frame_pkg::CMD_RDSR: out_sh_r <= {status_byte[6:0], 1'b0};
                    flash_frame_pkg::CMD_RDID: out_sh_r <= {id_byte[6:0], 1'b0};
                    default:                   out_sh_r <= {array_byte[6:0], 1'b0};
                endcase
                out_bit_r <= (op_r == flash_frame_pkg::CMD_RDSR) ? status_byte[7] :
                             (op_r == flash_frame_pkg::CMD_RDID) ? id_byte[7] :
                             array_byte[7];
            end else begin
                out_bit_r <= out_sh_r[7];
                out_sh_r  <= {out_sh_r[6:0], 1'b0};
            end
        end
    end

    // Drive the output only during an active read's data phase.
    always_ff @(negedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= active_r && !standby_r && is_read && !read_blocked &&
                     (!needs_addr || addr_done_r);
        end
    end
    assign so_dat = out_bit_r;

    // Frame end: the last link flops before select rises hold the result.
    // Aligned means the bit counter wrapped to zero after a whole number of bytes.
    logic       frame_tog_r;
    always_ff @(posedge spi_clk or negedge rstn) begin
        if (!rstn) begin
            pend_code_r     <= 4'h0;
            pend_addr_r     <= 24'h00_0000;
            frame_aligned_r <= 1'b0;
        end else if (!cs_n) begin
            pend_code_r     <= (active_r || (!have_op_r && bit_cnt_r == 3'h7)) ?
                               ((!have_op_r) ? 4'(op_nxt) : 4'(op_r)) : 4'h0;
            pend_addr_r     <= (active_r && needs_addr && !addr_done_r) ?
                               {addr_r[22:0], si} : addr_r;
            frame_aligned_r <= (bit_cnt_r == 3'h7);
        end
    end

    // Select rising is the frame event; toggle it across on its own edge.
    always_ff @(posedge cs_n or negedge rstn) begin
        if (!rstn) begin
            frame_tog_r <= 1'b0;
        end else begin
            frame_tog_r <= ~frame_tog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System domain: frame event, framing check, command FIFO.
    logic frame_evt;
    event_sync u_frame_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .src_toggle (frame_tog_r),
        .dst_pulse  (frame_evt)
    );

    // The pending fields are stable by the time the toggle settles.
    logic        write_type;
    logic        accept;
    logic [27:0] fifo_in;
    logic [27:0] fifo_out;
    logic        fifo_in_ready;
    logic [3:0]  pc;
    assign pc = pend_code_r;
    assign write_type = (pc != 4'(flash_frame_pkg::CMD_NONE)) &&
                        (pc != 4'(flash_frame_pkg::CMD_READ)) &&
                        (pc != 4'(flash_frame_pkg::CMD_FAST_READ)) &&
                        (pc != 4'(flash_frame_pkg::CMD_RDSR)) &&
                        (pc != 4'(flash_frame_pkg::CMD_RDID));
    // Write-type frames pass only when they ended on a byte boundary.
    // Erase and program are refused while the core is busy.
    assign accept  = frame_evt && write_type && frame_aligned_r && !busy;
    assign fifo_in = {pc, pend_addr_r};

    sync_fifo #(
        .WIDTH (28),
        .DEPTH (`FIFO_DEPTH)
    ) u_cmd_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (accept),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (cmd_valid),
        .out_ready (cmd_ready),
        .out_data  (fifo_out)
    );
    assign cmd_code = fifo_out[27:24];
    assign cmd_addr = fifo_out[23:0];

    // Dropped pulse reports rejected write frames and FIFO overflow.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_dropped <= 1'b0;
        end else begin
            cmd_dropped <= frame_evt && write_type &&
                           (!frame_aligned_r || busy || !fifo_in_ready);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Geometry and lock map for the command at the FIFO head.
    logic [`NUM_BLOCKS-1:0] block_lock_r;
    logic [15:0]            low_sec_lock_r;
    logic [15:0]            high_sec_lock_r;
    logic [5:0]             hb;
    logic [3:0]             hs;
    logic                   end_block;
    logic                   lock_op;
    logic                   unlock_op;

    assign hb        = cmd_addr[`BLOCK_BITS+5:`BLOCK_BITS];
    assign hs        = cmd_addr[`BLOCK_BITS-1:`SECTOR_BITS];
    assign end_block = (hb == 6'h00) || (hb == `LAST_BLOCK);
    assign lock_op   = cmd_valid && cmd_ready &&
                       cmd_code == 4'(flash_frame_pkg::CMD_LOCK);
    assign unlock_op = cmd_valid && cmd_ready &&
                       cmd_code == 4'(flash_frame_pkg::CMD_UNLOCK);

    // Sector address and block number of the head command.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            addr_sector <= 10'h000;
            addr_block  <= 6'h00;
        end else begin
            addr_sector <= cmd_addr[21:12];
            addr_block  <= hb;
        end
    end

    // Lock bits per block; the two end blocks use per-sector bits instead.
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_sec
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    low_sec_lock_r[g]  <= 1'b0;
                    high_sec_lock_r[g] <= 1'b0;
                end else if ((lock_op || unlock_op) && hs == 4'(g)) begin
                    if (hb == 6'h00) low_sec_lock_r[g] <= lock_op;
                    if (hb == `LAST_BLOCK) high_sec_lock_r[g] <= lock_op;
                end
            end
        end
        for (g = 0; g < `NUM_BLOCKS; g++) begin : g_blk
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    block_lock_r[g] <= 1'b0;
                end else if ((lock_op || unlock_op) && !end_block && hb == 6'(g)) begin
                    block_lock_r[g] <= lock_op;
                end
            end
        end
    endgenerate

    // Lock state that covers the head command's address.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            addr_locked <= 1'b0;
        end else if (hb == 6'h00) begin
            addr_locked <= low_sec_lock_r[hs];
        end else if (hb == `LAST_BLOCK) begin
            addr_locked <= high_sec_lock_r[hs];
        end else begin
            addr_locked <= block_lock_r[hb];
        end
    end
endmodule : flash_frame
`default_nettype wire

// ---- design/flash_frame_regs.svh ----
// Constants for the serial flash command framing front end.
// Included by the design files; definitions only.
`ifndef FLASH_FRAME_REGS_SVH
`define FLASH_FRAME_REGS_SVH
`define ADDR_TOP        24'h3F_FFFF
`define SECTOR_BITS     12
`define BLOCK_BITS      16
`define NUM_SECTORS     1024
`define NUM_BLOCKS      64
`define LAST_BLOCK      6'h3F
`define OP_READ         8'h03
`define OP_FAST_READ    8'h0B
`define OP_RDSR         8'h05
`define OP_RDID         8'h9F
`define OP_WREN         8'h06
`define OP_WRDI         8'h04
`define OP_SE           8'h20
`define OP_BE           8'hD8
`define OP_PP           8'h02
`define OP_SBLK         8'h36
`define OP_SBULK        8'h39
`define FIFO_DEPTH      32
`endif

// ---- design/flash_frame_pkg.sv ----
// Types shared by the framing front end and its core-side logic.
// Assumes nothing of its surroundings.
`default_nettype none
package flash_frame_pkg;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_READ, CMD_FAST_READ, CMD_RDSR, CMD_RDID, CMD_WREN,
        CMD_WRDI, CMD_SE, CMD_BE, CMD_PP, CMD_LOCK, CMD_UNLOCK
    } cmd_t;
endpackage : flash_frame_pkg
`default_nettype wire

// ---- design/sync_fifo.sv ----
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    logic             push;
    logic             pop;

    // Full when the pointers differ only in the wrap bit.
    assign in_ready  = (wr_r ^ rd_r) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_r != rd_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_r[AW-1:0]];

    // Pointer update.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop)  rd_r <= rd_r + 1'b1;
        end
    end

    // Storage; no reset needed since reads are gated by the pointers.
    always_ff @(posedge sys_clk) begin
        if (push) mem[wr_r[AW-1:0]] <= in_data;
    end
endmodule : sync_fifo
`default_nettype wire

// ---- design/event_sync.sv ----
// Toggle-based event crossing from the link clock into sys_clk.
// Assumes the source raises at most one toggle per few destination cycles.
`timescale 1ns/100ps
`default_nettype none
module event_sync (
    // Destination clock and reset.
    input  wire logic sys_clk,
    input  wire logic rstn,
    // Source toggle and destination pulse.
    input  wire logic src_toggle,
    output logic      dst_pulse
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Two-flop synchroniser, then an edge detector on the settled copy.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= src_toggle;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign dst_pulse = s2_r ^ s3_r;
endmodule : event_sync
`default_nettype wire

// ---- tb/flash_frame_sva.sv ----
// Checker for the framing front end, bound to its top module.
// Assumes all watched ports are sampled on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module flash_frame_sva (
    // Clock and reset.
    input wire logic        sys_clk,
    input wire logic        rstn,
    // Link pins.
    input wire logic        cs_n,
    input wire logic        so_oe,
    // Core side.
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [3:0]  cmd_code,
    input wire logic [23:0] cmd_addr,
    input wire logic        addr_locked,
    input wire logic [9:0]  addr_sector,
    input wire logic [5:0]  addr_block,
    input wire logic        cmd_dropped
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    logic pop;

    // A head leaves the buffer only when both sides agree.
    assign pop = cmd_valid && cmd_ready;

    ////////////////////////////////////////////////
    standby_hiz_a: assert property (cs_n |-> !so_oe)
        else $error("serial output driven while deselected");
    // The map is guarded by valid, since an empty buffer shows stale words.
    sector_map_a: assert property ($past(cmd_valid) |->
        addr_sector == $past(cmd_addr[21:12]))
        else $error("sector index does not follow the address");
    block_map_a: assert property ($past(cmd_valid) |->
        addr_block == $past(cmd_addr[21:16]))
        else $error("block index does not follow the address");
    drop_pulse_a: assert property (cmd_dropped |=> !cmd_dropped)
        else $error("drop indication longer than one cycle");
    drop_quiet_a: assert property (cmd_dropped && !cmd_valid |=> !cmd_valid)
        else $error("rejected frame was queued");
    drop_framed_a: assert property (cmd_dropped |-> cs_n)
        else $error("drop raised inside a frame");
    head_hold_a: assert property (cmd_valid && !cmd_ready |=>
        cmd_valid && $stable(cmd_code) && $stable(cmd_addr))
        else $error("queued command changed before its pop");
    write_only_a: assert property (cmd_valid |-> cmd_code >= 4'h5 && cmd_code <= 4'hB)
        else $error("read command reached the core queue");
    lock_hold_a: assert property (cmd_valid && $past(cmd_valid) && $stable(cmd_addr)
        && !pop && !$past(pop) |=> $stable(addr_locked))
        else $error("lock indication moved without a pop");

    // Main scenarios.
    cover property (pop);
    cover property (cmd_dropped);
    cover property ($rose(so_oe));
    cover property (cmd_valid && addr_locked);
endmodule : flash_frame_sva
`default_nettype wire

// ---- tb/spi_host.sv ----
// Host SPI master model driving clock, select and data in.
// Assumes the bench calls xfer once per frame; clock stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module spi_host (
    // Pins toward the device.
    output logic      spi_clk,
    output logic      cs_n,
    output logic      si,
    // Device serial output.
    input  wire logic so_dat,
    input  wire logic so_oe
);
    // Idle pins before the first frame.
    initial begin
        spi_clk = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
    end

    ////////////////////////////////////////////////
    // One frame: n bits out MSB first, then m bits in; 32 ns clock period.
    task automatic xfer(input logic [31:0] d, input int n, input int m,
                        input logic cpol, output logic [7:0] din, output logic oe_all);
        int i;
        din     = 8'h00;
        oe_all  = 1'b1;
        spi_clk = cpol;
        #7;
        cs_n = 1'b0;
        for (i = 0; i < n; i++) begin
            spi_clk = 1'b0;
            si      = d[31-i];
            #16;
            spi_clk = 1'b1;
            #16;
        end
        // A released line shows a changing pattern, never the last bit.
        for (i = 0; i < m; i++) begin
            spi_clk = 1'b0;
            si      = ~si;
            #16;
            spi_clk = 1'b1;
            din     = {din[6:0], so_oe ? so_dat : ~din[0]};
            oe_all  = oe_all & so_oe;
            #16;
        end
        spi_clk = cpol;
        #16;
        cs_n = 1'b1;
        si   = ~si;
        #16;
    endtask : xfer
endmodule : spi_host
`default_nettype wire

// ---- tb/serial_flash_command_framing_test.sv ----
// Self-checking bench for the framing front end.
// Assumes the host model owns the link pins and the bench the core side.
`timescale 1ns/100ps
`default_nettype none
`include "flash_frame_regs.svh"
module serial_flash_command_framing_test;
    logic        sys_clk, rstn, spi_clk, cs_n, si, so_dat, so_oe, oe;
    logic        cmd_valid, cmd_ready, busy, addr_locked, cmd_dropped, drop_seen;
    logic [3:0]  cmd_code;
    logic [23:0] cmd_addr;
    logic [9:0]  addr_sector;
    logic [5:0]  addr_block;
    logic [7:0]  status_byte, id_byte, array_byte, rd;
    int          miscompares, cmp_count, cycles, i;

    flash_frame u_dut (.sys_clk(sys_clk), .rstn(rstn), .spi_clk(spi_clk), .cs_n(cs_n),
        .si(si), .so_dat(so_dat), .so_oe(so_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_addr(cmd_addr), .busy(busy), .status_byte(status_byte),
        .id_byte(id_byte), .array_byte(array_byte), .addr_locked(addr_locked),
        .addr_sector(addr_sector), .addr_block(addr_block), .cmd_dropped(cmd_dropped));
    spi_host u_host (.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so_dat(so_dat), .so_oe(so_oe));

    // System clock; the ceiling stops a hung wait.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    // A drop lasts one cycle, so it is caught in a flag.
    always @(posedge sys_clk) if (cmd_dropped === 1'b1) drop_seen <= 1'b1;

    ////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic frame(input logic [31:0] d, input int n, input int m, input logic cpol);
        drop_seen = 1'b0;
        u_host.xfer(d, n, m, cpol, rd, oe);
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : frame

    // Waits for the head, judges it with its geometry, then pops it.
    task automatic pop(input logic [3:0] c, input logic [23:0] a, input logic lk);
        int n;
        n = 0;
        while (cmd_valid !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        repeat (2) @(posedge sys_clk);
        #1;
        cmp("cmd_valid", 24'h00_0001, 24'(cmd_valid));
        cmp("cmd_code", 24'(c), 24'(cmd_code));
        cmp("cmd_addr", a, cmd_addr);
        cmp("addr_sector", 24'(a[21:12]), 24'(addr_sector));
        cmp("addr_block", 24'(a[21:16]), 24'(addr_block));
        cmp("addr_locked", 24'(lk), 24'(addr_locked));
        cmd_ready = 1'b1;
        @(posedge sys_clk);
        #1;
        cmd_ready = 1'b0;
    endtask : pop

    ////////////////////////////////////////////////
    task automatic t_basic();
        frame({`OP_SE, 24'h3F_8123}, 32, 0, 1'b0);
        pop(flash_frame_pkg::CMD_SE, 24'h3F_8123, 1'b0);
        frame({`OP_BE, 24'h12_3456}, 32, 0, 1'b1);
        pop(flash_frame_pkg::CMD_BE, 24'h12_3456, 1'b0);
    endtask : t_basic

    task automatic t_reject();
        frame({8'hFF, 24'h00_0000}, 32, 8, 1'b0);
        cmp("so_oe", 24'h00_0000, 24'(oe));
        cmp("cmd_valid", 24'h00_0000, 24'(cmd_valid));
        frame({`OP_SE, 24'h00_1000}, 31, 0, 1'b0);
        cmp("dropped", 24'h00_0001, 24'(drop_seen));
        frame({`OP_WREN, 24'h00_0000}, 9, 0, 1'b1);
        cmp("dropped", 24'h00_0001, 24'(drop_seen));
        cmp("cmd_valid", 24'h00_0000, 24'(cmd_valid));
        frame({`OP_WRDI, 24'h00_0000}, 8, 0, 1'b0);
        pop(flash_frame_pkg::CMD_WRDI, 24'h00_0000, 1'b0);
    endtask : t_reject

    task automatic t_reads();
        frame({`OP_RDSR, 24'h00_0000}, 8, 8, 1'b0);
        cmp("status", 24'h00_005A, 24'(rd));
        cmp("so_oe", 24'h00_0001, 24'(oe));
        frame({`OP_RDID, 24'h00_0000}, 8, 8, 1'b1);
        cmp("ident", 24'h00_003C, 24'(rd));
        frame({`OP_READ, 24'h00_0100}, 32, 16, 1'b0);
        cmp("array", 24'h00_00A5, 24'(rd));
        frame({`OP_READ, 24'h00_0100}, 32, 5, 1'b1);
        cmp("partial", 24'h00_0014, 24'(rd));
        frame({`OP_FAST_READ, 24'h00_0200}, 32, 8, 1'b1);
        cmp("fast", 24'h00_00A5, 24'(rd));
        busy = 1'b1;
        frame({`OP_READ, 24'h00_0100}, 32, 8, 1'b0);
        cmp("so_oe", 24'h00_0000, 24'(oe));
        frame({`OP_SE, 24'h00_0000}, 32, 0, 1'b0);
        cmp("dropped", 24'h00_0001, 24'(drop_seen));
        cmp("cmd_valid", 24'h00_0000, 24'(cmd_valid));
        busy = 1'b0;
    endtask : t_reads

    task automatic t_lock();
        frame({`OP_SBLK, 24'h00_1000}, 32, 0, 1'b0);
        pop(flash_frame_pkg::CMD_LOCK, 24'h00_1000, 1'b0);
        frame({`OP_SE, 24'h00_1234}, 32, 0, 1'b0);
        pop(flash_frame_pkg::CMD_SE, 24'h00_1234, 1'b1);
        frame({`OP_SE, 24'h00_0234}, 32, 0, 1'b0);
        pop(flash_frame_pkg::CMD_SE, 24'h00_0234, 1'b0);
        frame({`OP_SBLK, 24'h02_0000}, 32, 0, 1'b1);
        pop(flash_frame_pkg::CMD_LOCK, 24'h02_0000, 1'b0);
        frame({`OP_SE, 24'h02_F000}, 32, 0, 1'b0);
        pop(flash_frame_pkg::CMD_SE, 24'h02_F000, 1'b1);
        frame({`OP_SBULK, 24'h02_0000}, 32, 0, 1'b0);
        pop(flash_frame_pkg::CMD_UNLOCK, 24'h02_0000, 1'b1);
        frame({`OP_SE, 24'h02_F000}, 32, 0, 1'b1);
        pop(flash_frame_pkg::CMD_SE, 24'h02_F000, 1'b0);
    endtask : t_lock

    // Fills the queue with the core stalled, overflows it, then drains it.
    task automatic t_fifo();
        for (i = 0; i < 32; i++) begin
            if (i % 2 == 0) frame({`OP_WREN, 24'h00_0000}, 8, 0, 1'b0);
            else frame({`OP_PP, 24'h3F_0000}, 32, 0, 1'b1);
        end
        frame({`OP_WRDI, 24'h00_0000}, 8, 0, 1'b0);
        cmp("dropped", 24'h00_0001, 24'(drop_seen));
        for (i = 0; i < 32; i++) begin
            if (i % 2 == 0) pop(flash_frame_pkg::CMD_WREN, 24'h00_0000, 1'b0);
            else pop(flash_frame_pkg::CMD_PP, 24'h3F_0000, 1'b0);
        end
        cmp("cmd_valid", 24'h00_0000, 24'(cmd_valid));
    endtask : t_fifo

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////
    // Reset for six cycles, then the scenarios in turn.
    initial begin
        rstn        = 1'b0;
        cmd_ready   = 1'b0;
        busy        = 1'b0;
        drop_seen   = 1'b0;
        status_byte = 8'h5A;
        id_byte     = 8'h3C;
        array_byte  = 8'hA5;
        repeat (6) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        t_basic();
        t_reject();
        t_reads();
        t_lock();
        t_fifo();
        end_of_test();
    end
endmodule : serial_flash_command_framing_test

bind flash_frame flash_frame_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n),
    .so_oe(so_oe), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .addr_locked(addr_locked), .addr_sector(addr_sector),
    .addr_block(addr_block), .cmd_dropped(cmd_dropped));
`default_nettype wire
